/* File: ecid_sync.sv */
// package of shared constants plus the input synchroniser and falling-edge detector
package ecid_pkg;
   localparam int CLK_PERIOD_NS = 4;
   localparam int NS_PER_MS = 1000000;
   localparam int CYC_PER_MS = (NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DIV_W = 20;
   localparam int MS_W = 8;
   localparam int PANEL_W = 7;
   localparam int GPIN_W = 5;
   localparam int SYNC_W = PANEL_W + GPIN_W;
   // input bit positions in the synchroniser vector
   localparam int IN_STROBE = 7;
   localparam int IN_CAL = 8;
   localparam int IN_ZADJ = 9;
   localparam int IN_PRINT = 10;
   localparam int IN_GATE = 11;
   // times in milliseconds
   localparam logic [MS_W-1:0] LOAD_SETTLE_MS = 8'h46;
   localparam logic [MS_W-1:0] CAL_RUN_MS = 8'h37;
   localparam logic [MS_W-1:0] EOC_WIDTH_RST = 8'h01;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_RESET = 8'h08;
   localparam logic [7:0] OFS_EOC_WIDTH = 8'h0C;
   // control register fields
   localparam int CTRL_MEASURE_STROBE_N_EXT = 0;
   localparam int CTRL_CAL_MANUAL = 1;
   localparam int CTRL_RATE_LO = 2;
   localparam int CTRL_CMP_MANUAL = 4;
   localparam int CTRL_BEEP_EN = 5;
   localparam int CTRL_SERIAL_OUT = 6;
   localparam int CTRL_FAULT_FREE = 7;
   localparam int CTRL_EOC_PULSE = 8;
   localparam int CTRL_W = 9;
   // slow rate, auto cal, internal trigger, beep on, serial off, free-running fault, eoc hold
   localparam logic [CTRL_W-1:0] CTRL_RST = 9'h0AC;
   // reset command bits
   localparam int RST_SETTINGS = 0;
   localparam int RST_ALL = 1;
   // status fields
   localparam int STAT_GPIN_LO = 0;
   localparam int STAT_LOAD_BUSY = 5;
   localparam int STAT_CAL_BUSY = 6;
   localparam int STAT_PANEL_LO = 8;
   localparam int STAT_EOC = 16;
   localparam int STAT_JUDGE = 17;
   typedef enum logic [1:0]
   {
      ECID_RATE_EXTRA_QUICK = 2'h0,
      ECID_RATE_FAST = 2'h1,
      ECID_RATE_MEDIUM = 2'h2,
      ECID_RATE_SLOW = 2'h3
   } ecid_rate_t;
   typedef enum logic [0:0]
   {
      ECID_ST_IDLE = 1'h0,
      ECID_ST_LOAD_WAIT = 1'h1
   } ecid_state_t;
endpackage

module ecid_sync #(
   parameter int W = 12
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] free_running_fault_mode_i,
   output logic [W-1:0] level_o,
   output logic [W-1:0] fall_o
);
   logic [W-1:0] meta;
   logic [W-1:0] prev;

   generate
      if (W < 1)
      begin : g_bad
         $error("ecid_sync needs at least one input");
      end
   endgenerate

   // idle level is high: open inputs read as one
   genvar b;
   generate
      for (b = 0; b < W; b++)
      begin : g_bit
         always_ff @(posedge clk_i)
         begin
            if (!rst_n_i)
            begin
               meta[b] <= 1'b1;
               level_o[b] <= 1'b1;
               prev[b] <= 1'b1;
               fall_o[b] <= 1'b0;
            end
            else
            begin
               meta[b] <= free_running_fault_mode_i[b];
               level_o[b] <= meta[b];
               prev[b] <= level_o[b];
               fall_o[b] <= prev[b] & ~level_o[b];
            end
         end
      end
   endgenerate
endmodule

/* File: ecid_top.sv */
// external control input decoder with AHB-Lite register slave
//
// Contract
// - on strobe, load panel chosen by select lines, then measure under external trigger.
// - low line is 0; panel number is complement of lines, bit 0 LSB.
// - pattern equal to previous strobe's pattern skips the load.
// - all ones or all zeros pattern never loads a panel.
// - new settings take effect no sooner than 70 ms after load.
// - external trigger: one measurement once a strobe load completes.
// - no pattern-driven loads while under remote control.
// - external trigger: each strobe falling edge outside a load wait starts one measurement.
// - internal trigger: strobe does not start measurements.
// - strobe always drives statistics, memory and serial value output.
// - manual cal at non-slow rate: cal falling edge starts self-cal.
// - a self-calibration run lasts about 55 ms.
// - slow rate ignores the calibration request entirely.
// - each zero-adjust falling edge runs exactly one zero adjustment.
// - each hardcopy falling edge sends current value to printer.
// - manual comparator mode: judgment enabled only while gate is low.
// - the five control inputs are readable as general inputs.
// - reset restores settings only, or settings and stored panels.
// - reset gives serial output off, free-running fault, eoc hold 1 ms.
// - key beep setting, enabled by default.
// - eoc pulse mode lasts configured width; hold mode stays asserted.
// - eoc and reference-state outputs come up asserted.
module ecid_top #(
   parameter int P_CYC_PER_MS = ecid_pkg::CYC_PER_MS
) (
   input wire logic CLK_SYS_I,
   input wire logic RST_N_I,
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [2:0] HSIZE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   output logic [31:0] HRDATA_O,
   output logic HREADYOUT_O,
   output logic HRESP_O,
   input wire logic [6:0] PANEL_SEL_N_I,
   input wire logic MEASURE_STROBE_N_I,
   input wire logic CAL_REQUEST_N_I,
   input wire logic ZERO_ADJUST_REQUEST_N_I,
   input wire logic HARDCOPY_REQUEST_N_I,
   input wire logic MANUAL_JUDGE_GATE_N_I,
   input wire logic REMOTE_I,
   input wire logic MEAS_DONE_I,
   output logic MEAS_START_O,
   output logic PANEL_LOAD_O,
   output logic [6:0] PANEL_NUM_O,
   output logic STAT_STROBE_O,
   output logic CAL_START_O,
   output logic CAL_BUSY_O,
   output logic ZERO_ADJ_O,
   output logic PRINT_O,
   output logic JUDGE_EN_O,
   output logic EOC_O,
   output logic INDEX_O,
   output logic SETTINGS_RESET_O,
   output logic PANEL_WIPE_O
);
   generate
      if (P_CYC_PER_MS < 2 || P_CYC_PER_MS >= (1 << ecid_pkg::DIV_W))
      begin : g_bad
         $error("P_CYC_PER_MS out of range for the ms divider");
      end
   endgenerate

   logic [ecid_pkg::SYNC_W-1:0] lvl;
   logic [ecid_pkg::SYNC_W-1:0] fall;
   ecid_sync #(.W(ecid_pkg::SYNC_W)) u_sync (
      .clk_i(CLK_SYS_I),
      .rst_n_i(RST_N_I),
      .free_running_fault_mode_i({MANUAL_JUDGE_GATE_N_I, HARDCOPY_REQUEST_N_I, ZERO_ADJUST_REQUEST_N_I,
                CAL_REQUEST_N_I, MEASURE_STROBE_N_I, PANEL_SEL_N_I}),
      .level_o(lvl),
      .fall_o(fall)
   );

   // ---- millisecond enable divider
   logic [ecid_pkg::DIV_W-1:0] div_cnt;
   wire ms_tick = (div_cnt == ecid_pkg::DIV_W'(P_CYC_PER_MS - 1));
   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I || ms_tick)
         div_cnt <= '0;
      else
         div_cnt <= div_cnt + 1'b1;
   end

   // ---- register state
   logic [ecid_pkg::CTRL_W-1:0] ctrl;
   logic [ecid_pkg::MS_W-1:0] eoc_width;
   wire measure_strobe_n_ext = ctrl[ecid_pkg::CTRL_MEASURE_STROBE_N_EXT];
   wire cal_manual = ctrl[ecid_pkg::CTRL_CAL_MANUAL];
   wire [1:0] rate = ctrl[ecid_pkg::CTRL_RATE_LO +: 2];
   wire cmp_manual = ctrl[ecid_pkg::CTRL_CMP_MANUAL];
   wire eoc_pulse = ctrl[ecid_pkg::CTRL_EOC_PULSE];

   // ---- AHB-Lite slave, zero wait states
   logic dp_write;
   logic [7:0] dp_addr;
   wire ap_valid = HSEL_I && HTRANS_I[1] && HREADY_I;
   wire [7:0] ap_addr = HADDR_I[7:0];
   wire ap_mapped = (HADDR_I[31:8] == 24'h000000);
   wire wr_ctrl = dp_write && (dp_addr == ecid_pkg::OFS_CTRL);
   wire wr_reset = dp_write && (dp_addr == ecid_pkg::OFS_RESET);
   wire wr_width = dp_write && (dp_addr == ecid_pkg::OFS_EOC_WIDTH);
   wire do_rst_all = wr_reset && HWDATA_I[ecid_pkg::RST_ALL];
   wire do_rst_set = wr_reset && (HWDATA_I[ecid_pkg::RST_SETTINGS] || do_rst_all);

   logic [31:0] status;
   logic [31:0] next_rdata;
   always_comb
   begin
      next_rdata = 32'h00000000;
      if (ap_mapped)
      begin
         case (ap_addr)
            ecid_pkg::OFS_CTRL: next_rdata = {23'h000000, ctrl};
            ecid_pkg::OFS_STATUS: next_rdata = status;
            ecid_pkg::OFS_EOC_WIDTH: next_rdata = {24'h000000, eoc_width};
            default: next_rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
      begin
         dp_write <= 1'b0;
         dp_addr <= 8'h00;
         HRDATA_O <= 32'h00000000;
         HREADYOUT_O <= 1'b1;
         HRESP_O <= 1'b0;
      end
      else
      begin
         dp_write <= ap_valid && HWRITE_I && ap_mapped;
         dp_addr <= ap_addr;
         HRDATA_O <= (ap_valid && !HWRITE_I) ? next_rdata : 32'h00000000;
         HREADYOUT_O <= 1'b1;
         HRESP_O <= 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I || do_rst_set)
      begin
         ctrl <= ecid_pkg::CTRL_RST;
         eoc_width <= ecid_pkg::EOC_WIDTH_RST;
      end
      else
      begin
         if (wr_ctrl)
            ctrl <= HWDATA_I[ecid_pkg::CTRL_W-1:0];
         if (wr_width)
            eoc_width <= HWDATA_I[ecid_pkg::MS_W-1:0];
      end
   end

   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
      begin
         SETTINGS_RESET_O <= 1'b0;
         PANEL_WIPE_O <= 1'b0;
      end
      else
      begin
         SETTINGS_RESET_O <= do_rst_set;
         PANEL_WIPE_O <= do_rst_all;
      end
   end

   // ---- panel select decode
   wire [6:0] pat = lvl[6:0];
   wire strobe_fall = fall[ecid_pkg::IN_STROBE];
   logic [6:0] prev_pat;
   ecid_pkg::ecid_state_t st;
   logic [ecid_pkg::MS_W-1:0] load_cnt;
   logic meas_after;
   wire pat_valid = (pat != 7'h7F) && (pat != 7'h00);
   wire load_ok = strobe_fall && (st == ecid_pkg::ECID_ST_IDLE) && !REMOTE_I
                  && pat_valid && (pat != prev_pat);
   wire load_done = (st == ecid_pkg::ECID_ST_LOAD_WAIT) && ms_tick
                    && (load_cnt == 8'h01);
   wire direct_meas = strobe_fall && measure_strobe_n_ext && (st == ecid_pkg::ECID_ST_IDLE) && !load_ok;
   wire next_meas = direct_meas || (load_done && meas_after);

   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
      begin
         st <= ecid_pkg::ECID_ST_IDLE;
         load_cnt <= 8'h00;
         meas_after <= 1'b0;
      end
      else
      begin
         case (st)
            ecid_pkg::ECID_ST_IDLE:
            begin
               if (load_ok)
               begin
                  // one extra tick: the divider phase is arbitrary at the load
                  st <= ecid_pkg::ECID_ST_LOAD_WAIT;
                  load_cnt <= ecid_pkg::LOAD_SETTLE_MS + 8'h01;
                  meas_after <= measure_strobe_n_ext;
               end
            end
            ecid_pkg::ECID_ST_LOAD_WAIT:
            begin
               if (load_done)
                  st <= ecid_pkg::ECID_ST_IDLE;
               else if (ms_tick)
                  load_cnt <= load_cnt - 8'h01;
            end
            default: st <= ecid_pkg::ECID_ST_IDLE;
         endcase
      end
   end

   // the previous pattern follows every strobe, taken or not
   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
         prev_pat <= 7'h7F;
      else if (strobe_fall)
         prev_pat <= pat;
   end

   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
      begin
         PANEL_LOAD_O <= 1'b0;
         PANEL_NUM_O <= 7'h00;
         MEAS_START_O <= 1'b0;
         STAT_STROBE_O <= 1'b0;
      end
      else
      begin
         PANEL_LOAD_O <= load_ok;
         if (load_ok)
            PANEL_NUM_O <= ~pat;
         MEAS_START_O <= next_meas;
         STAT_STROBE_O <= strobe_fall;
      end
   end

   // ---- self calibration
   logic [ecid_pkg::MS_W-1:0] cal_cnt;
   wire cal_ok = fall[ecid_pkg::IN_CAL] && cal_manual && !CAL_BUSY_O
                 && (rate != ecid_pkg::ECID_RATE_SLOW);
   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
      begin
         CAL_START_O <= 1'b0;
         CAL_BUSY_O <= 1'b0;
         cal_cnt <= 8'h00;
      end
      else
      begin
         CAL_START_O <= cal_ok;
         if (cal_ok)
         begin
            CAL_BUSY_O <= 1'b1;
            cal_cnt <= ecid_pkg::CAL_RUN_MS;
         end
         else if (CAL_BUSY_O && ms_tick)
         begin
            cal_cnt <= cal_cnt - 8'h01;
            if (cal_cnt == 8'h01)
               CAL_BUSY_O <= 1'b0;
         end
      end
   end

   // ---- zero adjust, hardcopy, judgment gate
   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
      begin
         ZERO_ADJ_O <= 1'b0;
         PRINT_O <= 1'b0;
         JUDGE_EN_O <= 1'b0;
      end
      else
      begin
         ZERO_ADJ_O <= fall[ecid_pkg::IN_ZADJ];
         PRINT_O <= fall[ecid_pkg::IN_PRINT];
         JUDGE_EN_O <= !cmp_manual || !lvl[ecid_pkg::IN_GATE];
      end
   end

   // ---- end of conversion and reference-state outputs
   logic [ecid_pkg::MS_W-1:0] eoc_cnt;
   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
      begin
         EOC_O <= 1'b1;
         INDEX_O <= 1'b1;
         eoc_cnt <= 8'h00;
      end
      else
      begin
         if (MEAS_START_O)
         begin
            EOC_O <= 1'b0;
            INDEX_O <= 1'b0;
         end
         else if (MEAS_DONE_I)
         begin
            EOC_O <= 1'b1;
            INDEX_O <= 1'b1;
            eoc_cnt <= eoc_width;
         end
         else if (eoc_pulse && EOC_O && ms_tick)
         begin
            // a width of zero behaves like one
            if (eoc_cnt <= 8'h01)
               EOC_O <= 1'b0;
            eoc_cnt <= eoc_cnt - 8'h01;
         end
      end
   end

   assign status = {14'h0000, JUDGE_EN_O, EOC_O, 1'b0, PANEL_NUM_O, 1'b0, CAL_BUSY_O,
                    (st == ecid_pkg::ECID_ST_LOAD_WAIT), ~lvl[ecid_pkg::IN_GATE:ecid_pkg::IN_STROBE]};

   // ---- assertions
   default clocking cb @(posedge CLK_SYS_I);
   endclocking
   default disable iff (!RST_N_I);

   logic [ecid_pkg::MS_W:0] ticks_since_load;
   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I || load_ok)
         ticks_since_load <= '0;
      else if (ms_tick && !ticks_since_load[ecid_pkg::MS_W])
         ticks_since_load <= ticks_since_load + 1'b1;
   end

   strobe_meas_a: assert property (direct_meas |=> MEAS_START_O && !PANEL_LOAD_O)
      else $error("external strobe did not start one measurement");
   int_measure_strobe_n_a: assert property (strobe_fall && !measure_strobe_n_ext |=> !MEAS_START_O)
      else $error("strobe started a measurement under internal trigger");
   repeat_skip_a: assert property (strobe_fall && pat == prev_pat |=> !PANEL_LOAD_O)
      else $error("repeated pattern caused a panel load");
   edge_pat_a: assert property (strobe_fall && !pat_valid |=> !PANEL_LOAD_O)
      else $error("all ones or zeros pattern caused a panel load");
   remote_block_a: assert property (REMOTE_I && strobe_fall |=> !PANEL_LOAD_O)
      else $error("panel load while remote");
   panel_num_a: assert property (PANEL_LOAD_O |-> PANEL_NUM_O == ~$past(pat))
      else $error("panel number not the complement of select lines");
   settle_a: assert property (load_done |-> ticks_since_load >= 9'(ecid_pkg::LOAD_SETTLE_MS))
      else $error("load completed before the settle time");
   load_meas_a: assert property (load_done && meas_after |=> MEAS_START_O ##1 !MEAS_START_O)
      else $error("no single measurement after panel load");
   slow_cal_a: assert property (fall[ecid_pkg::IN_CAL] && rate == ecid_pkg::ECID_RATE_SLOW
                                |=> !CAL_START_O)
      else $error("calibration started at slow rate");
   cal_busy_a: assert property ($rose(CAL_BUSY_O) |-> CAL_START_O ##1 !CAL_START_O [*8])
      else $error("calibration busy not tied to one start pulse");
   zadj_a: assert property (fall[ecid_pkg::IN_ZADJ] |=> ZERO_ADJ_O ##1 !ZERO_ADJ_O)
      else $error("zero adjust request not a single pulse");
   judge_a: assert property (cmp_manual && lvl[ecid_pkg::IN_GATE] && $stable(cmp_manual)
                             |=> !JUDGE_EN_O)
      else $error("judgment enabled while gate high");

   load_then_meas_c: cover property (load_done && meas_after ##1 MEAS_START_O);
   direct_meas_c: cover property (direct_meas ##1 MEAS_START_O);
   cal_run_c: cover property (CAL_START_O ##1 CAL_BUSY_O);
   eoc_pulse_c: cover property (eoc_pulse && $fell(EOC_O));
endmodule

/* File: ecid_panel_model.sv */
// switch panel model that drives the control connector inputs
module ecid_panel_model (
   input wire logic clk_i,
   output logic [6:0] panel_sel_n_o,
   output logic strobe_n_o,
   output logic cal_n_o,
   output logic zadj_n_o,
   output logic print_n_o,
   output logic gate_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] ctl_n;
   initial
   begin
      panel_sel_n_o = 7'h7F;
      ctl_n = 5'h1F;
   end
   assign strobe_n_o = ctl_n[0];
   assign cal_n_o = ctl_n[1];
   assign zadj_n_o = ctl_n[2];
   assign print_n_o = ctl_n[3];
   assign gate_n_o = ctl_n[4];
   // low line is a zero, pattern settles before the strobe
   task automatic set_panel(input logic [6:0] pat);
      panel_sel_n_o <= pat;
      repeat (4) @(posedge clk_i);
   endtask
   // index 0 strobe, 1 cal, 2 zero, 3 print; high again long enough to part edges
   task automatic press(input int idx);
      ctl_n[idx] <= 1'b0;
      repeat (4) @(posedge clk_i);
      ctl_n[idx] <= 1'b1;
      repeat (4) @(posedge clk_i);
   endtask
   task automatic set_gate(input logic lvl);
      ctl_n[4] <= lvl;
      repeat (4) @(posedge clk_i);
   endtask
   // controller allows the settle time after a load
   task automatic wait_ms(input int n, input int cyc_per_ms);
      repeat (n * cyc_per_ms) @(posedge clk_i);
   endtask
endmodule

/* File: ecid_top_bench.sv */
// self-checking bench for the control input decoder
module ecid_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CPM = 10;
   localparam int MS = 0, PL = 1, SS = 2, CS = 3, ZA = 4, PR = 5, SR = 6, PW = 7;
   logic clk, rst_n, hsel, hwrite, remote, meas_done;
   wire hready, hresp;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, rd;
   wire [31:0] hrdata;
   wire [6:0] sel_n, panel_num;
   wire strobe_n, cal_n, zadj_n, print_n, gate_n;
   wire meas_start, panel_load, stat_strobe, cal_start, cal_busy, zero_adj, print_out;
   wire judge_en, eoc, index_out, set_rst, wipe;
   int fail_count, tests_run, cyc, n;
   int cnt [8] = '{default: 0};
   int last [8] = '{default: 0};
   int b [8];
   wire [7:0] pv = {wipe, set_rst, print_out, zero_adj, cal_start, stat_strobe, panel_load,
      meas_start};

   ecid_top #(.P_CYC_PER_MS(CPM)) i_dut (
      .CLK_SYS_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
      .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
      .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .PANEL_SEL_N_I(sel_n),
      .MEASURE_STROBE_N_I(strobe_n), .CAL_REQUEST_N_I(cal_n), .ZERO_ADJUST_REQUEST_N_I(zadj_n),
      .HARDCOPY_REQUEST_N_I(print_n), .MANUAL_JUDGE_GATE_N_I(gate_n), .REMOTE_I(remote),
      .MEAS_DONE_I(meas_done), .MEAS_START_O(meas_start), .PANEL_LOAD_O(panel_load),
      .PANEL_NUM_O(panel_num), .STAT_STROBE_O(stat_strobe), .CAL_START_O(cal_start),
      .CAL_BUSY_O(cal_busy), .ZERO_ADJ_O(zero_adj), .PRINT_O(print_out),
      .JUDGE_EN_O(judge_en), .EOC_O(eoc), .INDEX_O(index_out),
      .SETTINGS_RESET_O(set_rst), .PANEL_WIPE_O(wipe)
   );

   ecid_panel_model i_model (
      .clk_i(clk), .panel_sel_n_o(sel_n), .strobe_n_o(strobe_n), .cal_n_o(cal_n),
      .zadj_n_o(zadj_n), .print_n_o(print_n), .gate_n_o(gate_n)
   );

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // pulse counts and the cycle of the latest pulse on each output
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      for (int i = 0; i < 8; i++)
      begin
         if (pv[i] === 1'b1)
         begin
            cnt[i] <= cnt[i] + 1;
            last[i] <= cyc;
         end
      end
   end

   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         fail_count++;
         $display("unexpected at %0t: expected %h got %h", $time, e, g);
      end
   endtask

   task automatic chk1(input logic e, input logic g);
      chk({31'h0, e}, {31'h0, g});
   endtask

   function automatic logic [31:0] dl(input int i);
      return cnt[i] - b[i];
   endfunction

   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      rd = hrdata;
      chk1(1'b0, hresp);
   endtask

   task automatic done_pulse();
      meas_done <= 1'b1;
      @(posedge clk);
      meas_done <= 1'b0;
      @(posedge clk);
   endtask

   task automatic fin(input string name);
      $display("test %s finished, mismatches so far %0d", name, fail_count);
   endtask

   task automatic t_regs();
      ahb(1'b0, ecid_pkg::OFS_CTRL, 32'h0);
      chk(32'h0000_00AC, rd);
      ahb(1'b0, ecid_pkg::OFS_EOC_WIDTH, 32'h0);
      chk(32'h0000_0001, rd);
      ahb(1'b0, ecid_pkg::OFS_RESET, 32'h0);
      chk(32'h0, rd);
      ahb(1'b0, 8'h10, 32'h0);
      chk(32'h0, rd);
      chk1(1'b1, eoc);
      chk1(1'b1, index_out);
      fin("registers");
   endtask

   task automatic t_load();
      ahb(1'b1, ecid_pkg::OFS_CTRL, 32'h0000_00AD);
      b = cnt;
      i_model.set_panel(7'h7C);
      i_model.press(0);
      n = 0;
      while (cnt[MS] == b[MS] && n < 900)
      begin
         @(posedge clk);
         n++;
      end
      chk(32'h1, dl(PL));
      chk(32'h3, {25'h0, panel_num});
      chk1(1'b1, (last[MS] - last[PL]) >= 700 && (last[MS] - last[PL]) <= 720);
      chk(32'h1, dl(MS));
      ahb(1'b0, ecid_pkg::OFS_STATUS, 32'h0);
      chk(32'h3, {25'h0, rd[14:8]});
      done_pulse();
      b = cnt;
      i_model.press(0);
      i_model.press(0);
      chk(32'h0, dl(PL));
      chk(32'h2, dl(MS));
      chk(32'h2, dl(SS));
      done_pulse();
      fin("panel load");
   endtask

   task automatic t_refuse();
      b = cnt;
      i_model.set_panel(7'h7F);
      i_model.press(0);
      i_model.set_panel(7'h00);
      i_model.press(0);
      chk(32'h0, dl(PL));
      remote <= 1'b1;
      i_model.set_panel(7'h7A);
      i_model.press(0);
      chk(32'h0, dl(PL));
      remote <= 1'b0;
      i_model.set_panel(7'h75);
      i_model.press(0);
      chk(32'h1, dl(PL));
      chk(32'h0A, {25'h0, panel_num});
      i_model.wait_ms(72, CPM);
      done_pulse();
      fin("refused loads");
   endtask

   task automatic t_internal();
      ahb(1'b1, ecid_pkg::OFS_CTRL, 32'h0000_00AC);
      b = cnt;
      i_model.press(0);
      chk(32'h0, dl(MS));
      chk(32'h1, dl(SS));
      fin("internal source");
   endtask

   task automatic t_cal();
      for (int r = 0; r < 3; r++)
      begin
         ahb(1'b1, ecid_pkg::OFS_CTRL, 32'h0000_00A2 | (r << 2));
         b = cnt;
         i_model.press(1);
         chk(32'h1, dl(CS));
         n = 0;
         while (cal_busy === 1'b1 && n < 700)
         begin
            @(posedge clk);
            n++;
         end
         chk1(1'b1, (cyc - last[CS]) >= 538 && (cyc - last[CS]) <= 552);
      end
      ahb(1'b1, ecid_pkg::OFS_CTRL, 32'h0000_00AE);
      b = cnt;
      i_model.press(1);
      chk(32'h0, dl(CS));
      chk1(1'b0, cal_busy);
      fin("self calibration");
   endtask

   task automatic t_zero_print();
      b = cnt;
      i_model.press(2);
      i_model.press(3);
      chk(32'h1, dl(ZA));
      chk(32'h1, dl(PR));
      fin("zero and print");
   endtask

   task automatic t_gate();
      ahb(1'b1, ecid_pkg::OFS_CTRL, 32'h0000_00BC);
      i_model.set_gate(1'b1);
      chk1(1'b0, judge_en);
      i_model.set_gate(1'b0);
      chk1(1'b1, judge_en);
      ahb(1'b0, ecid_pkg::OFS_STATUS, 32'h0);
      chk(32'h10, {27'h0, rd[4:0]});
      i_model.set_gate(1'b1);
      fin("manual gate");
   endtask

   task automatic t_eoc();
      ahb(1'b1, ecid_pkg::OFS_CTRL, 32'h0000_01AD);
      ahb(1'b1, ecid_pkg::OFS_EOC_WIDTH, 32'h3);
      i_model.press(0);
      chk1(1'b0, eoc);
      chk1(1'b0, index_out);
      done_pulse();
      n = 0;
      while (eoc === 1'b1 && n < 100)
      begin
         @(posedge clk);
         n++;
      end
      chk1(1'b1, n >= 18 && n <= 31);
      ahb(1'b1, ecid_pkg::OFS_CTRL, 32'h0000_00AD);
      i_model.press(0);
      done_pulse();
      repeat (60) @(posedge clk);
      chk1(1'b1, eoc);
      fin("end of conversion");
   endtask

   task automatic t_reset();
      ahb(1'b1, ecid_pkg::OFS_CTRL, 32'h0000_0143);
      ahb(1'b1, ecid_pkg::OFS_EOC_WIDTH, 32'h9);
      b = cnt;
      ahb(1'b1, ecid_pkg::OFS_RESET, 32'h1);
      repeat (3) @(posedge clk);
      chk(32'h1, dl(SR));
      chk(32'h0, dl(PW));
      ahb(1'b0, ecid_pkg::OFS_CTRL, 32'h0);
      chk(32'h0000_00AC, rd);
      ahb(1'b0, ecid_pkg::OFS_EOC_WIDTH, 32'h0);
      chk(32'h1, rd);
      b = cnt;
      ahb(1'b1, ecid_pkg::OFS_RESET, 32'h2);
      repeat (3) @(posedge clk);
      chk(32'h1, dl(PW));
      fin("reset scopes");
   endtask

   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial
   begin
      #200000;
      fail_count++;
      wrap_up();
   end

   initial
   begin
      {hsel, hwrite, remote, meas_done, rst_n} = 5'h0;
      {htrans, haddr, hwdata} = '0;
      cyc = 0;
      fail_count = 0;
      tests_run = 0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_regs();
      t_load();
      t_refuse();
      t_internal();
      t_cal();
      t_zero_print();
      t_gate();
      t_eoc();
      t_reset();
      wrap_up();
   end
endmodule
